//--- common/mmc_cfg.svh
// Constants of the memory map and core control register block.
// Assumes a 20-bit byte address space and byte-wide register access.
// Overview of operation
// - Upper region reads return selected flash bank
// - Select bit picks bank zero or one
// - Registers and RAM override the mirror
// - Mirror answers data reads, never fetches
// - Mirror select register resets zero, bit0 only
// - RAM spans its window for data, stack, code
// - Register banks live in RAM, no fetch
// - Extended register window; longer instructions
// - Counter advances by length or branch loads
// - Reset loads counter from reset vector
// - Vector low byte even, high byte odd
// - Status word resets 06H; restored from psw_restore_data
// - Enable flag gates all maskable requests
// - Enable flag cleared by DI, accept; set EI
// - Zero flag marks zero or equal result
// - Bank field records the selected bank
// - Half carry marks bit three carry, borrow
// - Requests below in-service priority are refused
// - Carry holds overflow, shift-out, bit accumulator
// - Stack pointer sixteen bits, RAM only
// - Decrement before push, increment after pop
`ifndef MMC_CFG_SVH
`define MMC_CFG_SVH
`define MMC_UPPER_BASE 20'hf0000
`define MMC_ESFR_BASE 20'hf0000
`define MMC_ESFR_LAST 20'hf07ff
`define MMC_RAM_BASE 20'hf7f00
`define MMC_RAM_LAST 20'hffeff
`define MMC_GPR_BASE 20'hffee0
`define MMC_SFR_BASE 20'hfff00
`define MMC_MIRROR_REG_ADDR 20'hffffe
`define MMC_MIRROR_REG_RESET 8'h00
`define MMC_PSW_RESET 8'h06
`define MMC_VEC_LO_ADDR 20'h00000
`define MMC_VEC_HI_ADDR 20'h00001
`define MMC_PSW_IE 7
`define MMC_PSW_Z 6
`define MMC_PSW_BANK_SELECT_BIT1 5
`define MMC_PSW_AC 4
`define MMC_PSW_BANK_SELECT_BIT0 3
`define MMC_PSW_INSERVICE_PRIORITY_BIT1 2
`define MMC_PSW_INSERVICE_PRIORITY_BIT0 1
`define MMC_PSW_CY 0
`endif

//--- common/mmc_pkg.sv
// Types shared by the memory map and control register block.
// Assumes mmc_cfg.svh holds the numeric constants.
package mmc_pkg;
	typedef enum logic [2:0] {
		RGN_NONE,
		RGN_FLASH,
		RGN_MIRROR,
		RGN_ESFR,
		RGN_RAM,
		RGN_GPR,
		RGN_SFR
	} mmc_region_type;
	typedef enum logic [1:0] {
		VS_REQ_LO,
		VS_REQ_HI,
		VS_GET_HI,
		VS_RUN
	} mmc_vec_state_type;
endpackage

//--- core/mmc_core.sv
// Address decoder, mirror select, program counter, status word and stack pointer.
// Assumes flash returns read data one enabled cycle after a read request.
`timescale 1ns/100ps
`default_nettype none
`include "mmc_cfg.svh"
module mmc_core
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic acc_valid,
	input wire logic [19:0] acc_addr,
	input wire logic acc_fetch,
	input wire logic acc_write,
	input wire logic acc_bit,
	input wire logic [2:0] acc_bit_sel,
	input wire logic [7:0] acc_wdata,
	output logic dec_valid_q,
	output mmc_pkg::mmc_region_type dec_region_q,
	output logic [19:0] dec_addr_q,
	output logic dec_fault_q,
	output logic dec_long_q,
	output logic [7:0] reg_rdata_q,
	output logic mirror_source_bit_q,
	output logic flash_rd_q,
	output logic [19:0] flash_addr_q,
	input wire logic [7:0] flash_rdata,
	output logic [19:0] program_counter_q,
	output logic cpu_ready_q,
	input wire logic pc_adv,
	input wire logic [2:0] pc_len,
	input wire logic pc_load,
	input wire logic [19:0] pc_target,
	output logic [7:0] processor_status_word_q,
	input wire logic disable_irq_instruction,
	input wire logic enable_irq_instruction,
	input wire logic bank_select_instruction,
	input wire logic [1:0] bank_sel,
	input wire logic flags_we,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic [7:0] alu_res,
	input wire logic alu_carry,
	input wire logic psw_restore,
	input wire logic [7:0] psw_restore_data,
	input wire logic irq_req,
	input wire logic [1:0] irq_prio,
	output logic irq_ack_q,
	output logic [15:0] stack_pointer_q,
	input wire logic sp_load,
	input wire logic [15:0] sp_wdata,
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic [1:0] stack_bytes,
	output logic [15:0] stack_addr_q,
	output logic stack_err_q
);
	import mmc_pkg::*;

	// ************************************************************
	// Address decode
	// ************************************************************
	mmc_region_type region_d;
	logic [19:0] map_addr_d;
	logic fault_d;
	logic reg_hit;
	logic irq_ok;
	logic [19:0] sp_full;
	logic [15:0] sp_next;
	mmc_vec_state_type vec_q;
	logic [7:0] vec_lo_q;

	assign reg_hit = acc_valid && (acc_addr == `MMC_MIRROR_REG_ADDR);

	always_comb
	begin
		region_d = RGN_FLASH;
		map_addr_d = acc_addr;
		fault_d = 1'b0;
		if (acc_addr >= `MMC_SFR_BASE)
			region_d = RGN_SFR;
		else if (acc_addr >= `MMC_GPR_BASE && acc_addr <= `MMC_RAM_LAST)
		begin
			region_d = RGN_GPR;
			fault_d = acc_fetch;
		end
		else if (acc_addr >= `MMC_RAM_BASE)
			region_d = RGN_RAM;
		else if (acc_addr <= `MMC_ESFR_LAST && acc_addr >= `MMC_ESFR_BASE)
			region_d = RGN_ESFR;
		else if (acc_addr >= `MMC_UPPER_BASE)
		begin
			region_d = RGN_MIRROR;
			map_addr_d = {3'h0, mirror_source_bit_q, acc_addr[15:0]};
			fault_d = acc_fetch || acc_write;
		end
		if (fault_d)
			region_d = RGN_NONE;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dec_valid_q <= 1'b0;
			dec_region_q <= RGN_NONE;
			dec_addr_q <= 20'h00000;
			dec_fault_q <= 1'b0;
			dec_long_q <= 1'b0;
		end
		else if (clk_en)
		begin
			dec_valid_q <= acc_valid;
			dec_region_q <= acc_valid ? region_d : RGN_NONE;
			dec_addr_q <= map_addr_d;
			dec_fault_q <= acc_valid && fault_d;
			dec_long_q <= acc_valid && (region_d == RGN_ESFR);
		end
	end

	// ************************************************************
	// Mirror select register
	// ************************************************************
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			mirror_source_bit_q <= 1'(`MMC_MIRROR_REG_RESET);
		else if (clk_en && reg_hit && acc_write)
		begin
			if (!acc_bit)
				mirror_source_bit_q <= acc_wdata[0];
			else if (acc_bit_sel == 3'h0)
				mirror_source_bit_q <= acc_wdata[0];
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata_q <= 8'h00;
		else if (clk_en)
			reg_rdata_q <= (reg_hit && !acc_write) ? {7'h00, mirror_source_bit_q} : 8'h00;
	end

	// ************************************************************
	// Reset vector load and program counter
	// ************************************************************
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			vec_q <= VS_REQ_LO;
			vec_lo_q <= 8'h00;
			flash_rd_q <= 1'b0;
			flash_addr_q <= 20'h00000;
			cpu_ready_q <= 1'b0;
		end
		else if (clk_en)
		begin
			case (vec_q)
				VS_REQ_LO:
				begin
					flash_rd_q <= 1'b1;
					flash_addr_q <= `MMC_VEC_LO_ADDR;
					vec_q <= VS_REQ_HI;
				end
				VS_REQ_HI:
				begin
					flash_addr_q <= `MMC_VEC_HI_ADDR;
					vec_q <= VS_GET_HI;
				end
				VS_GET_HI:
				begin
					vec_lo_q <= flash_rdata;
					flash_rd_q <= 1'b0;
					vec_q <= VS_RUN;
				end
				VS_RUN:
				begin
					flash_rd_q <= 1'b0;
					cpu_ready_q <= 1'b1;
				end
				default:
					vec_q <= VS_REQ_LO;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			program_counter_q <= 20'h00000;
		else if (clk_en)
		begin
			if (vec_q == VS_RUN && !cpu_ready_q)
				program_counter_q <= {4'h0, flash_rdata, vec_lo_q};
			else if (cpu_ready_q && pc_load)
				program_counter_q <= pc_target;
			else if (cpu_ready_q && pc_adv)
				program_counter_q <= program_counter_q + {17'h00000, pc_len};
		end
	end

	// ************************************************************
	// Status word and interrupt acceptance
	// ************************************************************
	assign irq_ok = processor_status_word_q[`MMC_PSW_IE] && irq_req &&
		(irq_prio <= processor_status_word_q[`MMC_PSW_INSERVICE_PRIORITY_BIT1:`MMC_PSW_INSERVICE_PRIORITY_BIT0]);

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			irq_ack_q <= 1'b0;
		else if (clk_en)
			irq_ack_q <= irq_ok && cpu_ready_q && !irq_ack_q;
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			processor_status_word_q <= `MMC_PSW_RESET;
		else if (clk_en && cpu_ready_q)
		begin
			if (irq_ok && !irq_ack_q)
			begin
				processor_status_word_q[`MMC_PSW_IE] <= 1'b0;
				processor_status_word_q[`MMC_PSW_INSERVICE_PRIORITY_BIT1:`MMC_PSW_INSERVICE_PRIORITY_BIT0] <= irq_prio;
			end
			else if (psw_restore)
				processor_status_word_q <= psw_restore_data;
			else if (disable_irq_instruction)
				processor_status_word_q[`MMC_PSW_IE] <= 1'b0;
			else if (enable_irq_instruction)
				processor_status_word_q[`MMC_PSW_IE] <= 1'b1;
			else if (bank_select_instruction)
			begin
				processor_status_word_q[`MMC_PSW_BANK_SELECT_BIT1] <= bank_sel[1];
				processor_status_word_q[`MMC_PSW_BANK_SELECT_BIT0] <= bank_sel[0];
			end
			else if (flags_we)
			begin
				processor_status_word_q[`MMC_PSW_Z] <= (alu_res == 8'h00);
				processor_status_word_q[`MMC_PSW_AC] <= alu_a[4] ^ alu_b[4] ^ alu_res[4];
				processor_status_word_q[`MMC_PSW_CY] <= alu_carry;
			end
		end
	end

	// ************************************************************
	// Stack pointer
	// ************************************************************
	assign sp_next = stack_push ? stack_pointer_q - {14'h0000, stack_bytes} :
		stack_pointer_q + {14'h0000, stack_bytes};
	assign sp_full = {4'hf, stack_pointer_q};

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stack_pointer_q <= 16'h0000;
			stack_addr_q <= 16'h0000;
		end
		else if (clk_en)
		begin
			if (sp_load)
				stack_pointer_q <= sp_wdata;
			else if (stack_push)
			begin
				stack_pointer_q <= sp_next;
				stack_addr_q <= sp_next;
			end
			else if (stack_pop)
			begin
				stack_addr_q <= stack_pointer_q;
				stack_pointer_q <= sp_next;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			stack_err_q <= 1'b0;
		else if (clk_en)
			stack_err_q <= (stack_push || stack_pop) &&
				(sp_full < `MMC_RAM_BASE || sp_full >= `MMC_GPR_BASE);
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	a_mirror_maps_bank: assert property (clk_en && acc_valid && !acc_fetch && !acc_write &&
		acc_addr >= 20'hf0800 && acc_addr < `MMC_RAM_BASE |=> dec_region_q == RGN_MIRROR &&
		dec_addr_q[19:16] == {3'h0, $past(mirror_source_bit_q)})
		else $error("mirror read mapped wrong");
	a_sfr_not_mirror: assert property (clk_en && acc_valid && acc_addr >= `MMC_SFR_BASE
		|=> dec_region_q == RGN_SFR)
		else $error("register window decoded as mirror");
	a_mirror_no_fetch: assert property (clk_en && acc_valid && acc_fetch &&
		acc_addr >= 20'hf0800 && acc_addr < `MMC_RAM_BASE |=> dec_fault_q && dec_region_q == RGN_NONE)
		else $error("fetch from mirror not refused");
	a_select_bit_only: assert property (clk_en && reg_hit && !acc_write |=> reg_rdata_q[7:1] == 7'h00
		&& reg_rdata_q[0] == $past(mirror_source_bit_q))
		else $error("mirror select read wrong");
	a_gpr_no_fetch: assert property (clk_en && acc_valid && acc_fetch && acc_addr >= `MMC_GPR_BASE &&
		acc_addr <= `MMC_RAM_LAST |=> dec_fault_q)
		else $error("fetch from register banks not refused");
	a_esfr_long: assert property (clk_en && acc_valid && acc_addr >= `MMC_ESFR_BASE &&
		acc_addr <= `MMC_ESFR_LAST |=> dec_long_q)
		else $error("extended window not flagged");
	a_pc_advance: assert property (clk_en && cpu_ready_q && pc_adv && !pc_load
		|=> program_counter_q == $past(program_counter_q) + 20'($past(pc_len)))
		else $error("counter advance wrong");
	a_vector_ready: assert property ($rose(cpu_ready_q) |-> program_counter_q[19:16] == 4'h0)
		else $error("reset vector outside first bank");
	a_ie_clear: assert property (clk_en && cpu_ready_q && disable_irq_instruction && !psw_restore
		|=> !processor_status_word_q[`MMC_PSW_IE])
		else $error("enable flag not cleared");
	a_irq_gated: assert property (irq_ack_q |-> $past(processor_status_word_q[`MMC_PSW_IE])
		&& $past(irq_prio) <= $past(processor_status_word_q[2:1]))
		else $error("request accepted against mask");
	a_zero_flag: assert property (clk_en && cpu_ready_q && flags_we && !psw_restore && !irq_ok &&
		!disable_irq_instruction && !enable_irq_instruction && !bank_select_instruction
		|=> processor_status_word_q[`MMC_PSW_Z] == ($past(alu_res) == 8'h00))
		else $error("zero flag wrong");
	a_push_predec: assert property (clk_en && stack_push && !sp_load
		|=> stack_addr_q == stack_pointer_q && stack_pointer_q == $past(stack_pointer_q) - 16'($past(stack_bytes)))
		else $error("push did not predecrement");

	c_mirror_bank1: cover property (mirror_source_bit_q && dec_region_q == RGN_MIRROR);
	c_irq_accept: cover property (irq_ack_q);
	c_push_pop: cover property (stack_push ##1 stack_pop);
endmodule
`default_nettype wire

//--- verif/mmc_core_tb.sv
// Self-checking bench for the memory map and control register block.
// Assumes mmc_core, mmc_pkg and mmc_cfg.svh are compiled ahead of it.
`timescale 1ns/100ps
`default_nettype none
`include "mmc_cfg.svh"
`define CHECK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
		end \
	end
module mmc_core_tb;
	import mmc_pkg::*;
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic clk_en, acc_valid, acc_fetch, acc_write, acc_bit, pc_adv, pc_load, flags_we, alu_carry;
	logic disable_irq_instruction, enable_irq_instruction, bank_select_instruction;
	logic psw_restore, irq_req, sp_load, stack_push, stack_pop;
	logic [2:0] acc_bit_sel, pc_len;
	logic [1:0] bank_sel, irq_prio, stack_bytes;
	logic [7:0] acc_wdata, alu_a, alu_b, alu_res, psw_restore_data, reg_rdata_q, processor_status_word_q;
	logic [7:0] flash_rdata = 8'h00;
	logic [19:0] last_addr = 20'h00000;
	logic [19:0] acc_addr, pc_target, dec_addr_q, flash_addr_q, program_counter_q;
	logic [15:0] sp_wdata, stack_pointer_q, stack_addr_q;
	logic dec_valid_q, dec_fault_q, dec_long_q, mirror_source_bit_q, flash_rd_q, cpu_ready_q, irq_ack_q, stack_err_q;
	mmc_region_type dec_region_q;
	int num_errors = 0;
	int compares = 0;

	mmc_core uut (.sys_clk, .sys_rst, .clk_en, .acc_valid, .acc_addr, .acc_fetch, .acc_write, .acc_bit,
		.acc_bit_sel, .acc_wdata, .dec_valid_q, .dec_region_q, .dec_addr_q, .dec_fault_q, .dec_long_q,
		.reg_rdata_q, .mirror_source_bit_q, .flash_rd_q, .flash_addr_q, .flash_rdata, .program_counter_q,
		.cpu_ready_q, .pc_adv, .pc_len, .pc_load, .pc_target, .processor_status_word_q,
		.disable_irq_instruction, .enable_irq_instruction, .bank_select_instruction, .bank_sel, .flags_we,
		.alu_a, .alu_b, .alu_res, .alu_carry, .psw_restore, .psw_restore_data, .irq_req, .irq_prio,
		.irq_ack_q, .stack_pointer_q, .sp_load, .sp_wdata, .stack_push, .stack_pop, .stack_bytes,
		.stack_addr_q, .stack_err_q);

	always #20 sys_clk = ~sys_clk;

	// ****************************************
	// Flash stand-in
	// ****************************************
	// Data answers the address requested one cycle earlier.
	always @(negedge sys_clk)
	begin
		flash_rdata <= last_addr[0] ? 8'h12 : 8'h34;
		last_addr <= flash_addr_q;
	end

	// ****************************************
	// Drivers
	// ****************************************
	task automatic idle;
		{acc_valid, acc_fetch, acc_write, acc_bit, pc_adv, pc_load, disable_irq_instruction,
			enable_irq_instruction, bank_select_instruction, flags_we, psw_restore, irq_req,
			sp_load, stack_push, stack_pop} = '0;
	endtask

	task automatic tick;
		@(posedge sys_clk);
		@(negedge sys_clk);
		idle;
	endtask

	task automatic dec(input logic [19:0] a, input logic [3:0] fw, input mmc_region_type r, input logic [19:0] ea);
		acc_valid = 1'h1;
		acc_addr = a;
		{acc_fetch, acc_write} = fw[3:2];
		tick;
		`CHECK(dec_valid_q, 1'h1)
		`CHECK(dec_region_q, r)
		`CHECK({dec_fault_q, dec_long_q}, fw[1:0])
		if (fw[1] == 1'h0)
			`CHECK(dec_addr_q, ea)
	endtask

	task automatic wr_sel(input logic b, input logic [2:0] s, input logic [7:0] d);
		acc_valid = 1'h1;
		acc_addr = `MMC_MIRROR_REG_ADDR;
		acc_write = 1'h1;
		acc_bit = b;
		acc_bit_sel = s;
		acc_wdata = d;
		tick;
		tick;
	endtask

	task automatic tally_and_finish;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_decode;
		dec(20'h00123, 4'h0, RGN_FLASH, 20'h00123);
		dec(20'hf0000, 4'h1, RGN_ESFR, 20'hf0000);
		dec(20'hf07ff, 4'h1, RGN_ESFR, 20'hf07ff);
		dec(20'hf0800, 4'h0, RGN_MIRROR, 20'h00800);
		dec(20'hf7eff, 4'h0, RGN_MIRROR, 20'h07eff);
		dec(20'hf1000, 4'ha, RGN_NONE, 20'h00000);
		dec(20'hf1000, 4'h6, RGN_NONE, 20'h00000);
		dec(20'hf7f00, 4'h8, RGN_RAM, 20'hf7f00);
		dec(20'hffedf, 4'h4, RGN_RAM, 20'hffedf);
		dec(20'hffee0, 4'h0, RGN_GPR, 20'hffee0);
		dec(20'hffeff, 4'ha, RGN_NONE, 20'h00000);
		dec(20'hfff00, 4'h0, RGN_SFR, 20'hfff00);
	endtask

	task automatic t_mirror;
		wr_sel(1'h0, 3'h0, 8'hff);
		dec(`MMC_MIRROR_REG_ADDR, 4'h0, RGN_SFR, `MMC_MIRROR_REG_ADDR);
		`CHECK(reg_rdata_q, 8'h01)
		dec(20'hf1234, 4'h0, RGN_MIRROR, 20'h11234);
		wr_sel(1'h1, 3'h3, 8'h00);
		`CHECK(mirror_source_bit_q, 1'h1)
		wr_sel(1'h1, 3'h0, 8'h00);
		`CHECK(mirror_source_bit_q, 1'h0)
		dec(20'hf1234, 4'h0, RGN_MIRROR, 20'h01234);
	endtask

	task automatic t_pc;
		pc_adv = 1'h1;
		pc_len = 3'h3;
		tick;
		`CHECK(program_counter_q, 20'h01237)
		pc_adv = 1'h1;
		pc_load = 1'h1;
		pc_target = 20'habcde;
		tick;
		`CHECK(program_counter_q, 20'habcde)
		clk_en = 1'h0;
		pc_adv = 1'h1;
		pc_len = 3'h3;
		tick;
		clk_en = 1'h1;
		`CHECK(program_counter_q, 20'habcde)
	endtask

	task automatic t_psw;
		irq_req = 1'h1;
		tick;
		`CHECK(irq_ack_q, 1'h0)
		enable_irq_instruction = 1'h1;
		tick;
		`CHECK(processor_status_word_q, 8'h86)
		irq_req = 1'h1;
		irq_prio = 2'h1;
		tick;
		`CHECK(irq_ack_q, 1'h1)
		`CHECK(processor_status_word_q, 8'h02)
		enable_irq_instruction = 1'h1;
		tick;
		irq_req = 1'h1;
		irq_prio = 2'h2;
		tick;
		`CHECK(irq_ack_q, 1'h0)
		disable_irq_instruction = 1'h1;
		tick;
		`CHECK(processor_status_word_q, 8'h02)
		for (int b = 0; b < 4; b++)
		begin
			bank_select_instruction = 1'h1;
			bank_sel = 2'(b);
			tick;
			`CHECK(processor_status_word_q, {2'h0, bank_sel[1], 1'h0, bank_sel[0], 3'h2})
		end
		flags_we = 1'h1;
		{alu_a, alu_b, alu_res, alu_carry} = {8'h0f, 8'h01, 8'h10, 1'h0};
		tick;
		`CHECK(processor_status_word_q, 8'h3a)
		flags_we = 1'h1;
		{alu_a, alu_b, alu_res, alu_carry} = {8'h80, 8'h80, 8'h00, 1'h1};
		tick;
		`CHECK(processor_status_word_q, 8'h6b)
		psw_restore = 1'h1;
		psw_restore_data = 8'h95;
		tick;
		`CHECK(processor_status_word_q, 8'h95)
	endtask

	task automatic t_stack;
		sp_load = 1'h1;
		sp_wdata = 16'hfe00;
		tick;
		stack_push = 1'h1;
		stack_bytes = 2'h2;
		tick;
		`CHECK({stack_pointer_q, stack_addr_q, stack_err_q}, {16'hfdfe, 16'hfdfe, 1'h0})
		stack_pop = 1'h1;
		tick;
		`CHECK({stack_pointer_q, stack_addr_q}, {16'hfe00, 16'hfdfe})
		sp_load = 1'h1;
		sp_wdata = 16'hfef0;
		tick;
		stack_pop = 1'h1;
		tick;
		`CHECK(stack_err_q, 1'h1)
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		idle;
		{acc_addr, acc_bit_sel, acc_wdata, pc_len, pc_target, bank_sel, alu_a, alu_b, alu_res, alu_carry,
			psw_restore_data, irq_prio, sp_wdata, stack_bytes} = '0;
		clk_en = 1'h1;
		repeat (16) @(negedge sys_clk);
		`CHECK(processor_status_word_q, `MMC_PSW_RESET)
		`CHECK(mirror_source_bit_q, 1'h0)
		sys_rst = 1'h0;
		for (int i = 0; i < 20 && cpu_ready_q !== 1'h1; i++)
			tick;
		if (cpu_ready_q !== 1'h1)
			num_errors++;
		else
		begin
			`CHECK(program_counter_q, 20'h01234)
			`CHECK({flash_rd_q, flash_addr_q}, {1'h0, `MMC_VEC_HI_ADDR})
			t_decode;
			t_mirror;
			t_pc;
			t_psw;
			t_stack;
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
